// *** usb_tx_endpoint_control.sv ***
// Transmit endpoint control/status registers and event handling
`timescale 1ns/1ps
module usb_tx_endpoint_control #(
  parameter int PKT_SLOTS = 2,     // Packets the FIFO can hold
  parameter bit SHARED_FIFO = 1'b1 // FIFO shared between directions
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic fifo_byte_wr_i,  // Byte written into the FIFO
  input wire logic in_token_i,      // IN token arrived
  input wire logic pkt_sent_i,      // Packet transmission finished
  input wire logic ack_seen_i,      // ACK received with pkt_sent_i
  input wire logic stall_sent_i,    // STALL handshake transmitted
  input wire logic stall_rx_i,      // STALL handshake received, host role
  input wire logic no_handshake_i,  // Attempt got no handshake, host role
  input wire logic nak_timeout_i,   // NAK limit reached, host role
  output logic packet_ready_o,
  output logic stall_handshake_o,
  output logic iso_o,
  output logic dir_tx_o,
  output logic toggle_o,
  output logic setup_token_o,
  output logic flush_o,
  output logic dma_req_o,
  output logic dma_style_o,
  output logic irq_o
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic auto_ready;
    logic iso;
    logic mode;
    logic dma_en;
    logic force_flip;
    logic dma_style;
    logic toggle;
    logic stall_sent;
    logic stall_req;
    logic underrun;
    logic occ;
    logic pr;
    logic nak;
    logic stall_rx_flag;
    logic setup;
    logic err;
    logic host;
    logic irq_en;
    logic [usb_tx_ep_pkg::MAXP_W-1:0] maxp;
    logic [1:0] retry;
    logic ack;
    logic [31:0] rdata;
    logic irq;
    logic flush;
    logic stall_hs;
    logic dir_tx;
    logic dma_req;
    logic setup_tok;  // Setup token select, registered with the role
  } ctl_t;
  ctl_t s;
  ctl_t next_s;

  tx_fifo_if fifo ();

  // Bus decode; a request is served on the edge that raises ack
  logic req;
  logic wr_lo;
  logic wr_hi;
  logic [15:0] peri_word;
  logic [15:0] host_word;
  logic tzero_req;
  logic discard_req;
  assign req = wb_cyc_i && wb_stb_i && !s.ack;
  assign wr_lo = req && wb_we_i && wb_sel_i[0];
  assign wr_hi = req && wb_we_i && wb_sel_i[1];
  assign tzero_req = wr_lo && wb_dat_i[usb_tx_ep_pkg::B_TZERO] &&
                     (wb_adr_i == usb_tx_ep_pkg::OFS_PERI_CSR || wb_adr_i == usb_tx_ep_pkg::OFS_HOST_CSR);
  assign discard_req = wr_lo && wb_dat_i[usb_tx_ep_pkg::B_DISCARD] &&
                       (wb_adr_i == usb_tx_ep_pkg::OFS_PERI_CSR || wb_adr_i == usb_tx_ep_pkg::OFS_HOST_CSR);

  // Read views; action bits and reserved bits read as zero
  always_comb begin
    peri_word = 16'h0000; // R25
    peri_word[usb_tx_ep_pkg::B_AUTO] = s.auto_ready;
    peri_word[usb_tx_ep_pkg::B_ISO] = s.iso;
    peri_word[usb_tx_ep_pkg::B_MODE] = s.mode;
    peri_word[usb_tx_ep_pkg::B_DMA_REQ_EN] = s.dma_en;
    peri_word[usb_tx_ep_pkg::B_FORCE] = s.force_flip;
    peri_word[usb_tx_ep_pkg::B_STYLE] = s.dma_style;
    peri_word[usb_tx_ep_pkg::B_PSTALL_SENT] = s.stall_sent;
    peri_word[usb_tx_ep_pkg::B_PSTALL_REQ] = s.stall_req;
    peri_word[usb_tx_ep_pkg::B_UNDERRUN] = s.underrun;
    peri_word[usb_tx_ep_pkg::B_OCC] = s.occ;
    peri_word[usb_tx_ep_pkg::B_READY] = s.pr;
    host_word = 16'h0000; // R20
    host_word[usb_tx_ep_pkg::B_AUTO] = s.auto_ready;
    host_word[usb_tx_ep_pkg::B_MODE] = s.mode;
    host_word[usb_tx_ep_pkg::B_DMA_REQ_EN] = s.dma_en;
    host_word[usb_tx_ep_pkg::B_FORCE] = s.force_flip;
    host_word[usb_tx_ep_pkg::B_STYLE] = s.dma_style;
    host_word[usb_tx_ep_pkg::B_TVAL] = s.toggle;
    host_word[usb_tx_ep_pkg::B_NAK] = s.nak;
    host_word[usb_tx_ep_pkg::B_HSTALL_RX] = s.stall_rx_flag;
    host_word[usb_tx_ep_pkg::B_HSETUP] = s.setup;
    host_word[usb_tx_ep_pkg::B_ERROR] = s.err;
    host_word[usb_tx_ep_pkg::B_OCC] = s.occ;
    host_word[usb_tx_ep_pkg::B_READY] = s.pr;
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Software writes go first, hardware events after, so a hardware event beats a software write
  always_comb begin
    next_s = s;
    next_s.ack = req;
    next_s.irq = 1'b0;
    next_s.flush = 1'b0;
    // Read data; unmapped offsets answer zero
    if (req) begin
      case (wb_adr_i)
        usb_tx_ep_pkg::OFS_PERI_CSR: next_s.rdata = {16'h0000, peri_word};
        usb_tx_ep_pkg::OFS_HOST_CSR: next_s.rdata = {16'h0000, host_word};
        usb_tx_ep_pkg::OFS_CONFIG: next_s.rdata = {30'h00000000, s.irq_en, s.host};
        usb_tx_ep_pkg::OFS_MAXP: next_s.rdata = {21'h000000, s.maxp};
        usb_tx_ep_pkg::OFS_STATUS: next_s.rdata = {30'h00000000, fifo.pkt_count};
        default: next_s.rdata = 32'h00000000;
      endcase
    end
    // Upper byte of either layout: modes and enables
    if (wr_hi && (wb_adr_i == usb_tx_ep_pkg::OFS_PERI_CSR || wb_adr_i == usb_tx_ep_pkg::OFS_HOST_CSR)) begin
      next_s.auto_ready = wb_dat_i[usb_tx_ep_pkg::B_AUTO];
      next_s.mode = wb_dat_i[usb_tx_ep_pkg::B_MODE];
      next_s.dma_en = wb_dat_i[usb_tx_ep_pkg::B_DMA_REQ_EN];
      next_s.force_flip = wb_dat_i[usb_tx_ep_pkg::B_FORCE];
      next_s.dma_style = wb_dat_i[usb_tx_ep_pkg::B_STYLE];
      if (wb_adr_i == usb_tx_ep_pkg::OFS_PERI_CSR) begin
        next_s.iso = wb_dat_i[usb_tx_ep_pkg::B_ISO]; // R04
      end else if (wb_dat_i[usb_tx_ep_pkg::B_TWE]) begin
        // Enable is never stored, so it is spent on this one write
        next_s.toggle = wb_dat_i[usb_tx_ep_pkg::B_TVAL]; // R22
      end
    end
    // Lower byte: flags clear on zero, action bits act on one only
    if (wr_lo && wb_adr_i == usb_tx_ep_pkg::OFS_PERI_CSR) begin
      if (!wb_dat_i[usb_tx_ep_pkg::B_PSTALL_SENT]) next_s.stall_sent = 1'b0; // R10
      next_s.stall_req = wb_dat_i[usb_tx_ep_pkg::B_PSTALL_REQ]; // R11
      if (!wb_dat_i[usb_tx_ep_pkg::B_UNDERRUN]) next_s.underrun = 1'b0; // R16
    end
    if (wr_lo && wb_adr_i == usb_tx_ep_pkg::OFS_HOST_CSR) begin
      if (!wb_dat_i[usb_tx_ep_pkg::B_NAK]) next_s.nak = 1'b0;
      if (!wb_dat_i[usb_tx_ep_pkg::B_HSTALL_RX]) next_s.stall_rx_flag = 1'b0;
      if (!wb_dat_i[usb_tx_ep_pkg::B_ERROR]) next_s.err = 1'b0;
      next_s.setup = wb_dat_i[usb_tx_ep_pkg::B_HSETUP];
      if (wb_dat_i[usb_tx_ep_pkg::B_HSETUP] && wb_dat_i[usb_tx_ep_pkg::B_READY]) begin
        next_s.toggle = 1'b0; // R24
      end
    end
    if (wr_lo && (wb_adr_i == usb_tx_ep_pkg::OFS_PERI_CSR || wb_adr_i == usb_tx_ep_pkg::OFS_HOST_CSR)) begin
      if (!wb_dat_i[usb_tx_ep_pkg::B_OCC]) next_s.occ = 1'b0; // R17
      if (wb_dat_i[usb_tx_ep_pkg::B_READY]) next_s.pr = 1'b1;
    end
    if (tzero_req) next_s.toggle = 1'b0; // R09
    // Discard only acts on a packet that is waiting
    if (discard_req && s.pr) begin // R14
      next_s.pr = 1'b0; // R13
      next_s.flush = 1'b1;
    end
    if (wr_lo && wb_adr_i == usb_tx_ep_pkg::OFS_CONFIG) begin
      next_s.host = wb_dat_i[usb_tx_ep_pkg::B_CFG_HOST];
      next_s.irq_en = wb_dat_i[usb_tx_ep_pkg::B_CFG_IRQEN];
    end
    if (wb_adr_i == usb_tx_ep_pkg::OFS_MAXP) begin
      if (wr_lo) next_s.maxp[7:0] = wb_dat_i[7:0];
      if (wr_hi) next_s.maxp[usb_tx_ep_pkg::MAXP_W-1:8] = wb_dat_i[usb_tx_ep_pkg::MAXP_W-1:8];
    end
    // Auto hand-over of a full packet
    if (fifo.full_pkt) next_s.pr = 1'b1; // R01
    if (in_token_i && !s.pr && !s.host) next_s.underrun = 1'b1; // R16
    // Transmission done: ACK or forced flip advances the toggle
    if (pkt_sent_i) begin
      next_s.pr = 1'b0; // R19
      if (s.pr && s.irq_en) next_s.irq = 1'b1; // R19
      if (ack_seen_i || s.force_flip) next_s.toggle = !next_s.toggle; // R07
      if (!ack_seen_i && s.force_flip) next_s.flush = 1'b1; // R07
      next_s.retry = 2'h0;
    end
    if (stall_sent_i && !s.host) begin
      next_s.stall_sent = 1'b1; // R10
      next_s.pr = 1'b0;
      next_s.flush = 1'b1;
    end
    if (stall_rx_i && s.host) begin
      next_s.stall_rx_flag = 1'b1; // R23
      next_s.pr = 1'b0;
      next_s.flush = 1'b1;
    end
    if (nak_timeout_i && s.host) next_s.nak = 1'b1;
    // Unanswered attempts count up; bulk and interrupt only
    if (no_handshake_i && s.host && !s.iso) begin
      if (s.retry == usb_tx_ep_pkg::RETRY_LIMIT - 2'h1) begin
        next_s.err = 1'b1; // R21
        next_s.irq = s.irq_en;
        next_s.retry = 2'h0;
      end else begin
        next_s.retry = s.retry + 2'h1;
      end
    end
    if (fifo.pkt_count != 2'h0) next_s.occ = 1'b1; // R17
    // Stall answer is gated off in isochronous and host use
    next_s.stall_hs = next_s.stall_req && !next_s.iso && !next_s.host; // R11 R12
    // Direction only matters when the FIFO is shared
    next_s.dir_tx = SHARED_FIFO ? next_s.mode : 1'b1; // R05
    next_s.dma_req = next_s.dma_en && (fifo.pkt_count < 2'(PKT_SLOTS)); // R06
    // Gated here so the pin comes straight from a flop
    next_s.setup_tok = next_s.setup && next_s.host; // R24
  end

  // Register the state
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // FIFO tracker
  // ****************************************************************
  // Commit is taken from the registered ready edge to keep the path short
  logic pr_d;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pr_d <= 1'b0;
    end else begin
      pr_d <= s.pr;
    end
  end
  assign fifo.byte_wr = fifo_byte_wr_i;
  assign fifo.auto_ready = s.auto_ready;
  assign fifo.maxp = s.maxp;
  assign fifo.commit = s.pr && !pr_d;
  assign fifo.drop_one = (pkt_sent_i && s.pr) || (discard_req && s.pr);
  // Each stall event flushes only in the role that honours it
  assign fifo.drop_all = (stall_sent_i && !s.host) || (stall_rx_i && s.host);

  tx_fifo_tracker #(.PKT_SLOTS(PKT_SLOTS)) u_tracker (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .fifo(fifo)
  );

  // Outputs straight from the state register
  assign wb_dat_o = s.rdata;
  assign wb_ack_o = s.ack;
  assign packet_ready_o = s.pr;
  assign stall_handshake_o = s.stall_hs;
  assign iso_o = s.iso;
  assign dir_tx_o = s.dir_tx;
  assign toggle_o = s.toggle;
  assign setup_token_o = s.setup_tok;
  assign flush_o = s.flush;
  assign dma_req_o = s.dma_req;
  assign dma_style_o = s.dma_style;
  assign irq_o = s.irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_stall_iso_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R12
    stall_handshake_o |-> !iso_o) else $error("stall answered on iso endpoint");
  a_underrun_set: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R16
    in_token_i && !s.pr && !s.host |=> s.underrun) else $error("underrun not flagged");
  a_sent_clears: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R19
    pkt_sent_i |=> !packet_ready_o) else $error("ready not cleared after send");
  a_done_irq: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R19
    pkt_sent_i && s.pr && s.irq_en |=> irq_o) else $error("no interrupt on send");
  a_stall_sent_flush: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R10
    stall_sent_i && !s.host |=> s.stall_sent && flush_o && !packet_ready_o) else $error("stall sent not handled");
  a_discard_ignored: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R14
    discard_req && !s.pr && !stall_sent_i && !stall_rx_i && !pkt_sent_i |=> !flush_o)
    else $error("discard acted without ready");
  a_dma_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R06
    dma_req_o |-> $past(next_s.dma_en)) else $error("dma request while disabled");
  a_error_third: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R21
    no_handshake_i && s.host && !s.iso && s.retry == 2'h2 |=> s.err) else $error("error not set on third miss");
  a_toggle_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R09
    tzero_req && !pkt_sent_i |=> !toggle_o) else $error("toggle not cleared");
  a_action_read_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R25
    wb_ack_o && $past(wb_adr_i) == usb_tx_ep_pkg::OFS_PERI_CSR |-> !wb_dat_o[6] && !wb_dat_o[3])
    else $error("action bit reads one");
  a_auto_ready: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R01
    fifo.full_pkt && !pkt_sent_i && !stall_sent_i && !stall_rx_i |=> packet_ready_o)
    else $error("auto ready missed");
endmodule

// *** usb_tx_ep_pkg.sv ***
// Constants shared by the transmit endpoint control block and its FIFO tracker
// Summary of operation
// [R01] Auto-ready raises packet-ready after full packet
// [R02] Software sets auto-ready before enabling DMA
// [R03] Short packets need packet-ready set by software
// [R04] Iso bit selects isochronous versus bulk/interrupt
// [R05] Direction bit matters only for shared FIFO
// [R06] DMA requests only while request enable set
// [R07] Force flip toggles and discards regardless of ACK
// [R08] Software sets request style one with DMA
// [R09] Toggle-zero write clears the data toggle
// [R10] Stall sent sets flag, flushes, drops ready
// [R11] Stall request answers IN tokens with STALL
// [R12] Stall request ignored for isochronous endpoint
// [R13] Discard drops packet, resets pointer, drops ready
// [R14] Discard ignored unless packet-ready is set
// [R15] Double buffer may need two discards
// [R16] IN token without packet-ready sets underrun
// [R17] Occupied flag set while a packet held
// [R18] Software sets packet-ready after loading packet
// [R19] Transmit done clears ready, raises interrupt
// [R20] Host role uses its own bit layout
// [R21] Three unanswered attempts set error, interrupt
// [R22] Toggle write enable permits one toggle write
// [R23] Host stall received sets flag, flushes, drops
// [R24] Setup select with ready clears toggle
// [R25] Action bits ignore zero, read zero
package usb_tx_ep_pkg;
  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_PERI_CSR = 8'h00; // Peripheral-role control/status
  localparam logic [7:0] OFS_HOST_CSR = 8'h04; // Host-role control/status
  localparam logic [7:0] OFS_CONFIG = 8'h08;   // Role and interrupt enable
  localparam logic [7:0] OFS_MAXP = 8'h0C;     // Maximum payload size
  localparam logic [7:0] OFS_STATUS = 8'h10;   // Packets held in FIFO
  // ****************************************************************
  // Bit positions, shared by both layouts unless marked; the last two are config register bits
  // ****************************************************************
  localparam int B_AUTO = 15;
  localparam int B_ISO = 14;        // Peripheral only
  localparam int B_MODE = 13;
  localparam int B_DMA_REQ_EN = 12;
  localparam int B_FORCE = 11;
  localparam int B_STYLE = 10;
  localparam int B_TWE = 9;         // Host only
  localparam int B_TVAL = 8;        // Host only
  localparam int B_NAK = 7;         // Host only
  localparam int B_TZERO = 6;
  localparam int B_PSTALL_SENT = 5; // Peripheral
  localparam int B_PSTALL_REQ = 4;  // Peripheral
  localparam int B_HSTALL_RX = 5;   // Host
  localparam int B_HSETUP = 4;      // Host
  localparam int B_DISCARD = 3;
  localparam int B_UNDERRUN = 2;    // Peripheral
  localparam int B_ERROR = 2;       // Host
  localparam int B_OCC = 1;
  localparam int B_READY = 0;
  localparam int B_CFG_HOST = 0;
  localparam int B_CFG_IRQEN = 1;
  // ****************************************************************
  // Sizes and counts
  // ****************************************************************
  localparam int MAXP_W = 11;                        // Payload size field width
  localparam logic [1:0] RETRY_LIMIT = 2'h3;         // Attempts before error
  localparam logic [MAXP_W-1:0] MAXP_RESET = 11'h000;
endpackage

// *** tx_fifo_if.sv ***
// Carrier between the endpoint controller and the FIFO tracker
`timescale 1ns/1ps
interface tx_fifo_if;
  logic byte_wr;                                 // One byte loaded this cycle
  logic auto_ready;                              // Auto hand-over enabled
  logic [usb_tx_ep_pkg::MAXP_W-1:0] maxp;        // Bytes per full packet
  logic commit;                                  // Packet handed to the core
  logic drop_one;                                // One packet sent or discarded
  logic drop_all;                                // Whole FIFO flushed
  logic full_pkt;                                // Full packet loaded, pulse
  logic [1:0] pkt_count;                         // Packets held
  modport ctrl (output byte_wr, auto_ready, maxp, commit, drop_one, drop_all, input full_pkt, pkt_count);
  modport tracker (input byte_wr, auto_ready, maxp, commit, drop_one, drop_all, output full_pkt, pkt_count);
endinterface

// *** tx_fifo_tracker.sv ***
// Byte and packet occupancy tracker for the transmit FIFO
`timescale 1ns/1ps
module tx_fifo_tracker #(
  parameter int PKT_SLOTS = 2
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  tx_fifo_if.tracker fifo
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [usb_tx_ep_pkg::MAXP_W-1:0] bytes; // Bytes of the packet being loaded
    logic [1:0] pkts;                        // Packets committed, not yet gone
    logic full;                              // Full packet pulse
  } trk_t;
  trk_t s;
  trk_t next_s;

  // Next state: count bytes, hand over full packets, track slots
  always_comb begin
    next_s = s;
    next_s.full = 1'b0;
    if (fifo.byte_wr) begin
      // Reaching the payload size closes the packet only when auto-ready is on
      if (fifo.auto_ready && (s.bytes + 11'h001 >= fifo.maxp)) begin
        next_s.full = 1'b1; // R01
        next_s.bytes = '0;
      end else begin
        next_s.bytes = s.bytes + 11'h001;
      end
    end
    if (fifo.commit && !fifo.drop_one && s.pkts < 2'(PKT_SLOTS)) begin
      next_s.pkts = s.pkts + 2'h1;
    end else if (fifo.drop_one && !fifo.commit && s.pkts != 2'h0) begin
      // One discard removes one packet; a double buffer needs two
      next_s.pkts = s.pkts - 2'h1; // R15
    end
    if (fifo.drop_all) begin
      next_s.pkts = 2'h0;
      next_s.bytes = '0;
    end
  end

  // Register the state
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign fifo.full_pkt = s.full;
  assign fifo.pkt_count = s.pkts;
endmodule

// *** usb_host_model.sv ***
// Far-side model: remote host issuing IN tokens and reporting each outcome
`timescale 1ns/1ps
module usb_host_model (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic token_req_i,       // Send one IN token
  input wire logic ack_i,             // Host answers data with ACK
  input wire logic packet_ready_i,
  input wire logic stall_handshake_i,
  output logic in_token_o,
  output logic pkt_sent_o,
  output logic ack_seen_o,
  output logic stall_sent_o
);
  // ************************************************************
  // Token, then one cycle later the handshake outcome
  // ************************************************************
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      in_token_o <= 1'b0;
      pkt_sent_o <= 1'b0;
      stall_sent_o <= 1'b0;
      ack_seen_o <= 1'b0;
    end else begin
      // Tokens go out whether or not data is ready
      in_token_o <= token_req_i;
      // A stall request wins over ready data
      stall_sent_o <= in_token_o & stall_handshake_i;
      pkt_sent_o <= in_token_o & ~stall_handshake_i & packet_ready_i;
      // Outside a completion the ACK level is junk that flips every cycle
      if (in_token_o & ~stall_handshake_i & packet_ready_i) begin
        ack_seen_o <= ack_i;
      end else begin
        ack_seen_o <= ~ack_seen_o;
      end
    end
  end
endmodule

// *** tb_top.sv ***
// Self-checking bench for the transmit endpoint control block
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] P = usb_tx_ep_pkg::OFS_PERI_CSR; // Short aliases
  localparam logic [7:0] H = usb_tx_ep_pkg::OFS_HOST_CSR;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req = 1'b0;       // Wishbone cyc and stb together
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic tok = 1'b0;       // IN token request
  logic ackh = 1'b0;      // Host ACKs the data
  logic bytew = 1'b0;     // FIFO byte load strobe
  logic [2:0] hev = 3'h0; // Host events: nak, no handshake, stall received
  logic [31:0] wb_dat_o, q;
  logic wb_ack_o, in_token, pkt_sent, ack_seen, stall_sent;
  logic rdy, stl, iso, dir, tgl, setup, flush, dreq, dsty, irq;
  int bad_count = 0;
  int checks = 0;
  int irqs = 0;           // Interrupt pulses seen
  int flushes = 0;        // Flush pulses seen
  int i0;
  initial forever #4 sys_clk_i = ~sys_clk_i;
  usb_tx_endpoint_control #(.PKT_SLOTS(2), .SHARED_FIFO(1'b1)) DUT (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'h3), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .fifo_byte_wr_i(bytew), .in_token_i(in_token), .pkt_sent_i(pkt_sent), .ack_seen_i(ack_seen),
    .stall_sent_i(stall_sent), .stall_rx_i(hev[0]), .no_handshake_i(hev[1]), .nak_timeout_i(hev[2]),
    .packet_ready_o(rdy), .stall_handshake_o(stl), .iso_o(iso), .dir_tx_o(dir), .toggle_o(tgl),
    .setup_token_o(setup), .flush_o(flush), .dma_req_o(dreq), .dma_style_o(dsty), .irq_o(irq));
  usb_host_model host (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .token_req_i(tok), .ack_i(ackh),
    .packet_ready_i(rdy), .stall_handshake_i(stl), .in_token_o(in_token), .pkt_sent_o(pkt_sent),
    .ack_seen_o(ack_seen), .stall_sent_o(stall_sent));
  // Pulse counters, since irq and flush stand one cycle only
  always @(posedge sys_clk_i) begin
    if (irq === 1'b1) irqs++;
    if (flush === 1'b1) flushes++;
  end
  task automatic results;
    if (bad_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic pin(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask
  // One classic cycle; the master never assumes how soon ack comes
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // Only the watchdog ends a wait that never sees ack
    do begin
      @(posedge sys_clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    req <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
    wb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), {16'h0, e}, q & {16'h0, m});
  endtask
  task automatic tokn(input logic a);
    @(posedge sys_clk_i);
    tok <= 1'b1;
    ackh <= a;
    @(posedge sys_clk_i);
    tok <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
  endtask
  task automatic bytes(input int n);
    @(posedge sys_clk_i);
    bytew <= 1'b1;
    repeat (n) @(posedge sys_clk_i);
    bytew <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
  endtask
  task automatic hp(input logic [2:0] m);
    @(posedge sys_clk_i);
    hev <= m;
    @(posedge sys_clk_i);
    hev <= 3'h0;
    repeat (3) @(posedge sys_clk_i);
  endtask
  // Watchdog against a hung handshake
  initial begin
    repeat (4000) @(posedge sys_clk_i);
    bad_count++;
    results();
  end
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(P, 16'h0000, 16'hFFFF);
    rd(8'h20, 16'h0000, 16'hFFFF);
    wb(1'b1, usb_tx_ep_pkg::OFS_CONFIG, 32'h2);
    wb(1'b1, usb_tx_ep_pkg::OFS_MAXP, 32'h4);
    wb(1'b1, P, 32'h8000);
    bytes(3);
    pin("ready short", 1'b0, rdy);
    bytes(1);
    pin("ready full", 1'b1, rdy);
    rd(P, 16'h8003, 16'hFFFF);
    tokn(1'b1);
    pin("ready sent", 1'b0, rdy);
    pin("toggle", 1'b1, tgl);
    chk("irqs", 32'h1, irqs);
    tokn(1'b1);
    rd(P, 16'h8004, 16'hFFFD);
    wb(1'b1, P, 32'h8000);
    rd(P, 16'h8000, 16'hFFFD);
    wb(1'b1, P, 32'h8040);
    pin("toggle zero", 1'b0, tgl);
    rd(P, 16'h8000, 16'hFFFD);
    wb(1'b1, P, 32'h0008);
    chk("flushes", 32'h0, flushes);
    wb(1'b1, P, 32'h0001);
    pin("ready manual", 1'b1, rdy);
    rd(usb_tx_ep_pkg::OFS_STATUS, 16'h0001, 16'h0003);
    wb(1'b1, P, 32'h0008);
    wb(1'b1, P, 32'h0008);
    pin("ready discard", 1'b0, rdy);
    chk("flushes", 32'h1, flushes);
    wb(1'b1, P, 32'h0011);
    pin("stall", 1'b1, stl);
    tokn(1'b1);
    pin("ready stall", 1'b0, rdy);
    rd(P, 16'h0030, 16'hFFFD);
    chk("flushes", 32'h2, flushes);
    wb(1'b1, P, 32'h0000);
    pin("stall off", 1'b0, stl);
    wb(1'b1, P, 32'h4010);
    pin("stall iso", 1'b0, stl);
    pin("iso", 1'b1, iso);
    wb(1'b1, P, 32'h8000);
    wb(1'b1, P, 32'h9400);
    pin("dma req", 1'b1, dreq);
    pin("dma style", 1'b1, dsty);
    wb(1'b1, P, 32'h8000);
    pin("dma off", 1'b0, dreq);
    wb(1'b1, P, 32'h2000);
    pin("dir", 1'b1, dir);
    wb(1'b1, P, 32'h0000);
    pin("dir", 1'b0, dir);
    i0 = irqs;
    wb(1'b1, P, 32'h0801);
    tokn(1'b0);
    pin("toggle force", 1'b1, tgl);
    chk("flushes", 32'h3, flushes);
    chk("irqs", i0 + 1, irqs);
    wb(1'b1, usb_tx_ep_pkg::OFS_CONFIG, 32'h3);
    rd(usb_tx_ep_pkg::OFS_CONFIG, 16'h0003, 16'h0003);
    wb(1'b1, H, 32'h0200);
    pin("toggle write", 1'b0, tgl);
    wb(1'b1, H, 32'h0100);
    pin("toggle locked", 1'b0, tgl);
    rd(H, 16'h0000, 16'h0300);
    wb(1'b1, H, 32'h0300);
    pin("toggle write", 1'b1, tgl);
    wb(1'b1, H, 32'h0011);
    pin("toggle setup", 1'b0, tgl);
    pin("setup", 1'b1, setup);
    hp(3'h5);
    pin("ready stall_received_flag", 1'b0, rdy);
    rd(H, 16'h00B0, 16'h00BD);
    chk("flushes", 32'h4, flushes);
    i0 = irqs;
    hp(3'h2);
    hp(3'h2);
    rd(H, 16'h0000, 16'h0004);
    hp(3'h2);
    rd(H, 16'h0004, 16'h0004);
    chk("irqs", i0 + 1, irqs);
    results();
  end
endmodule
